// ===== core/osa_pkg.sv
// Package of constants and types for the operand specifier address unit
package osa_pkg;

  // ==========================================================================
  // Specifier byte layout
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 4;
  localparam int REG_MSB  = 3;
  localparam int REG_LSB  = 0;
  localparam int LIT_MSB  = 5;
  localparam int NUM_GPR  = 16;

  localparam logic [3:0] MODE_LIT_MAX   = 4'h3;
  localparam logic [3:0] MODE_REG_DEF   = 4'h6;
  localparam logic [3:0] MODE_AUTODEC   = 4'h7;
  localparam logic [3:0] MODE_AUTOINC   = 4'h8;
  localparam logic [3:0] MODE_AUTOINC_D = 4'h9;
  localparam logic [3:0] PC_NUM         = 4'hF;

  // ==========================================================================
  // Operand size codes
  typedef enum logic [2:0] {
    OSA_SZ_BYTE,
    OSA_SZ_WORD,
    OSA_SZ_LONG,
    OSA_SZ_QUAD,
    OSA_SZ_FLOAT,
    OSA_SZ_DOUBLE
  } osa_size_type;

  // Kind of operand delivered
  typedef enum logic [2:0] {
    OSA_K_NONE,
    OSA_K_LITERAL,
    OSA_K_ADDRESS,
    OSA_K_IMMEDIATE,
    OSA_K_ABSOLUTE,
    OSA_K_RESERVED
  } osa_kind_type;

  localparam logic [31:0] PTR_STEP   = 32'h0000_0004;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
  localparam logic [63:0] ZERO_DWORD = 64'h0000_0000_0000_0000;

  // ==========================================================================
  // Floating literal layout
  localparam int FL_LITERAL_FRACTION_FIELD_LSB = 4;
  localparam int FL_EXP_LSB  = 7;
  localparam int FL_BIAS_BIT = 14;
  localparam logic [3:0] LIT_BYTES = 4'h4;

endpackage : osa_pkg

// ===== core/osa_gpr_file.sv
// General register file with one registered read port
`timescale 1ns/1ns
module osa_gpr_file
  import osa_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic [3:0]  rd_addr_in,
  output logic      [31:0] rd_data_out,
  input  wire logic        wr_en_in,
  input  wire logic [3:0]  wr_addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        wr_word_in
);

  logic [31:0] mem_reg [NUM_GPR];

  // ==========================================================================
  // Storage; a word load touches only the low half
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GPR; gi++)
    begin : g_gpr
      always_ff @(posedge mclk_in or negedge rstn_in)
      begin
        if (!rstn_in)
          mem_reg[gi] <= ZERO_WORD;
        else if (wr_en_in && wr_addr_in == 4'(gi))
        begin
          if (wr_word_in)
            mem_reg[gi][15:0] <= wr_data_in[15:0];
          else
            mem_reg[gi] <= wr_data_in;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rd_data_out <= ZERO_WORD;
    else
      rd_data_out <= mem_reg[rd_addr_in];
  end

endmodule : osa_gpr_file

// ===== core/osa_spec_unit.sv
// Operand specifier evaluation: address forming, register update, literals
// ==========================================================================
// Overview of operation
// - Mode 6: register contents are the operand address.
// - Mode 8 other than program counter: address is register, then register grows by operand size.
// - Mode 8 with program counter is reported as immediate form.
// - Mode 9 other than program counter: fetch pointer at register, it is the address; register plus 4.
// - Mode 9 with program counter is reported as absolute form.
// - Mode 7 other than program counter: register shrinks by size first, new value is the address.
// - Modes 0 to 3 are short literals, low six bits give 0 to 63.
// - Float literal: upper three bits exponent, lower three fraction.
// - Exponent goes to bits 7..9, fraction to bits 4..6.
// - Exponent is biased by 128.
// - Double literal is 64 bits, single literal 32 bits.
// - Memory operand spans size bytes from the address.
// - Word load into a register writes only the low 16 bits.
`timescale 1ns/1ns
module osa_spec_unit
  import osa_pkg::*;
(
  input  wire logic         mclk_in,
  input  wire logic         rstn_in,
  input  wire logic         spec_valid_in,
  input  wire logic [7:0]   spec_byte_in,
  input  wire osa_size_type spec_size_in,
  output logic              spec_ready_out,
  input  wire logic         ptr_ack_in,
  input  wire logic [31:0]  ptr_data_in,
  output logic              ptr_req_out,
  output logic [31:0]       ptr_addr_out,
  input  wire logic         gpr_load_in,
  input  wire logic [3:0]   gpr_load_num_in,
  input  wire logic [31:0]  gpr_load_data_in,
  input  wire osa_size_type gpr_load_size_in,
  output logic              opnd_valid_out,
  output osa_kind_type      opnd_kind_out,
  output logic [31:0]       opnd_addr_out,
  output logic [3:0]        opnd_bytes_out,
  output logic [63:0]       opnd_lit_out
);

  typedef enum {ST_IDLE, ST_READ, ST_EVAL, ST_PTR, ST_DONE} osa_state_type;

  osa_state_type state_reg;
  logic [3:0]    mode_reg;
  logic [3:0]    num_reg;
  osa_size_type  size_reg;
  logic [5:0]    lit_reg;
  logic [31:0]   rd_data;
  logic          wb_en;
  logic [31:0]   wb_data;
  logic [3:0]    rd_num;

  // ==========================================================================
  // Decoding helpers
  function automatic logic [3:0] size_bytes(input osa_size_type sz);
    case (sz)
      OSA_SZ_BYTE:   size_bytes = 4'h1;
      OSA_SZ_WORD:   size_bytes = 4'h2;
      OSA_SZ_LONG,
      OSA_SZ_FLOAT:  size_bytes = 4'h4;
      default:       size_bytes = 4'h8;
    endcase
  endfunction : size_bytes

  function automatic logic [63:0] float_lit(input logic [5:0] lit,
                                            input osa_size_type sz);
    logic [63:0] v;
    v = ZERO_DWORD;
    v[FL_LITERAL_FRACTION_FIELD_LSB +: 3] = lit[2:0];
    v[FL_EXP_LSB +: 3]  = lit[5:3];
    v[FL_BIAS_BIT]      = 1'b1;
    if (sz != OSA_SZ_DOUBLE)
      v[63:32] = ZERO_WORD;
    float_lit = v;
  endfunction : float_lit

  function automatic logic is_float(input osa_size_type sz);
    is_float = (sz == OSA_SZ_FLOAT) || (sz == OSA_SZ_DOUBLE);
  endfunction : is_float

  // ==========================================================================
  // Register file; the read port takes the offered register number in ST_IDLE, else the held one
  assign rd_num = spec_valid_in && state_reg == ST_IDLE
                  ? spec_byte_in[REG_MSB:REG_LSB] : num_reg;

  osa_gpr_file u_gpr
  (
    .mclk_in     (mclk_in),
    .rstn_in     (rstn_in),
    .rd_addr_in  (rd_num),
    .rd_data_out (rd_data),
    .wr_en_in    (wb_en || gpr_load_in),
    .wr_addr_in  (wb_en ? num_reg : gpr_load_num_in),
    .wr_data_in  (wb_en ? wb_data : gpr_load_data_in),
    .wr_word_in  (!wb_en && gpr_load_size_in == OSA_SZ_WORD)
  );

  // Write-back happens in ST_EVAL, before ST_IDLE accepts the next specifier
  always_comb
  begin
    wb_en   = 1'b0;
    wb_data = rd_data;
    if (state_reg == ST_EVAL && num_reg != PC_NUM)
    begin
      case (mode_reg)
        MODE_AUTOINC:
        begin
          wb_en   = 1'b1;
          wb_data = rd_data + 32'(size_bytes(size_reg));
        end
        MODE_AUTOINC_D:
        begin
          wb_en   = 1'b1;
          wb_data = rd_data + PTR_STEP;
        end
        MODE_AUTODEC:
        begin
          wb_en   = 1'b1;
          wb_data = rd_data - 32'(size_bytes(size_reg));
        end
        default:
        begin
          wb_en   = 1'b0;
          wb_data = rd_data;
        end
      endcase
    end
  end

  // ==========================================================================
  // Sequencer
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= ST_IDLE;
      mode_reg  <= 4'h0;
      num_reg   <= 4'h0;
      size_reg  <= OSA_SZ_BYTE;
      lit_reg   <= 6'h00;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (spec_valid_in)
          begin
            mode_reg  <= spec_byte_in[MODE_MSB:MODE_LSB];
            num_reg   <= spec_byte_in[REG_MSB:REG_LSB];
            size_reg  <= spec_size_in;
            lit_reg   <= spec_byte_in[LIT_MSB:0];
            state_reg <= ST_READ;
          end
        ST_READ:
          state_reg <= ST_EVAL;
        ST_EVAL:
          if (mode_reg == MODE_AUTOINC_D && num_reg != PC_NUM)
            state_reg <= ST_PTR;
          else
            state_reg <= ST_DONE;
        ST_PTR:
          if (ptr_ack_in)
            state_reg <= ST_DONE;
        ST_DONE:
          state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Pointer fetch for the deferred post-increment form
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ptr_req_out  <= 1'b0;
      ptr_addr_out <= ZERO_WORD;
    end
    else if (state_reg == ST_EVAL && mode_reg == MODE_AUTOINC_D && num_reg != PC_NUM)
    begin
      ptr_req_out  <= 1'b1;
      ptr_addr_out <= rd_data;
    end
    else if (ptr_ack_in)
      ptr_req_out <= 1'b0;
  end

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      spec_ready_out <= 1'b0;
    else
      spec_ready_out <= state_reg == ST_IDLE && !spec_valid_in;
  end

  // ==========================================================================
  // Operand result
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      opnd_valid_out <= 1'b0;
      opnd_kind_out  <= OSA_K_NONE;
      opnd_addr_out  <= ZERO_WORD;
      opnd_bytes_out <= 4'h0;
      opnd_lit_out   <= ZERO_DWORD;
    end
    else
    begin
      opnd_valid_out <= 1'b0;
      if (state_reg == ST_PTR && ptr_ack_in)
      begin
        opnd_valid_out <= 1'b1;
        opnd_kind_out  <= OSA_K_ADDRESS;
        opnd_addr_out  <= ptr_data_in;
        opnd_bytes_out <= size_bytes(size_reg);
      end
      else if (state_reg == ST_EVAL)
      begin
        opnd_bytes_out <= size_bytes(size_reg);
        opnd_addr_out  <= rd_data;
        opnd_lit_out   <= ZERO_DWORD;
        if (mode_reg <= MODE_LIT_MAX)
        begin
          opnd_valid_out <= 1'b1;
          opnd_kind_out  <= OSA_K_LITERAL;
          opnd_bytes_out <= is_float(size_reg) ? size_bytes(size_reg) : LIT_BYTES;
          if (is_float(size_reg))
            opnd_lit_out <= float_lit(lit_reg, size_reg);
          else
            opnd_lit_out <= {58'h0, lit_reg};
        end
        else if (mode_reg == MODE_AUTOINC && num_reg == PC_NUM)
        begin
          opnd_valid_out <= 1'b1;
          opnd_kind_out  <= OSA_K_IMMEDIATE;
        end
        else if (mode_reg == MODE_AUTOINC_D && num_reg == PC_NUM)
        begin
          opnd_valid_out <= 1'b1;
          opnd_kind_out  <= OSA_K_ABSOLUTE;
        end
        else if (mode_reg == MODE_REG_DEF || mode_reg == MODE_AUTOINC)
        begin
          opnd_valid_out <= 1'b1;
          opnd_kind_out  <= OSA_K_ADDRESS;
        end
        else if (mode_reg == MODE_AUTODEC)
        begin
          opnd_valid_out <= 1'b1;
          opnd_kind_out  <= OSA_K_ADDRESS;
          opnd_addr_out  <= wb_data;
        end
        else if (mode_reg != MODE_AUTOINC_D)
        begin
          // Other modes are handled elsewhere; flag them rather than guess
          opnd_valid_out <= 1'b1;
          opnd_kind_out  <= OSA_K_RESERVED;
        end
      end
    end
  end

  // ==========================================================================
  // Checks
  a_regdef_addr: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    state_reg == ST_EVAL && mode_reg == MODE_REG_DEF |=>
      opnd_valid_out && opnd_addr_out == $past(rd_data))
    else $error("register deferred address wrong");
  a_autoinc_step: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    state_reg == ST_EVAL && mode_reg == MODE_AUTOINC && num_reg != PC_NUM |=>
      u_gpr.mem_reg[num_reg] == $past(rd_data) + 32'(size_bytes(size_reg)))
    else $error("autoincrement step wrong");
  a_imm_kind: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    state_reg == ST_EVAL && mode_reg == MODE_AUTOINC && num_reg == PC_NUM |=>
      opnd_kind_out == OSA_K_IMMEDIATE)
    else $error("immediate form not reported");
  a_defer_step: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    state_reg == ST_EVAL && mode_reg == MODE_AUTOINC_D && num_reg != PC_NUM |->
      wb_data == rd_data + PTR_STEP ##1 ptr_req_out && ptr_addr_out == $past(rd_data))
    else $error("deferred pointer handling wrong");
  a_abs_kind: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    state_reg == ST_EVAL && mode_reg == MODE_AUTOINC_D && num_reg == PC_NUM |=>
      opnd_kind_out == OSA_K_ABSOLUTE)
    else $error("absolute form not reported");
  a_autodec_addr: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    state_reg == ST_EVAL && mode_reg == MODE_AUTODEC && num_reg != PC_NUM |=>
      opnd_addr_out == $past(rd_data) - 32'(size_bytes($past(size_reg))))
    else $error("autodecrement address wrong");
  a_lit_float: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    opnd_valid_out && opnd_kind_out == OSA_K_LITERAL && opnd_bytes_out == 4'h8 |->
      opnd_lit_out[FL_BIAS_BIT] && opnd_lit_out[3:0] == 4'h0)
    else $error("double literal layout wrong");
  a_wb_before_next: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    wb_en |=> !spec_ready_out ##1 state_reg != ST_EVAL)
    else $error("write-back overlaps next specifier");

  c_lit: cover property (@(posedge mclk_in) opnd_valid_out && opnd_kind_out == OSA_K_LITERAL);
  c_dec: cover property (@(posedge mclk_in) wb_en && mode_reg == MODE_AUTODEC);
  c_ptr: cover property (@(posedge mclk_in) ptr_req_out && ptr_ack_in);

endmodule : osa_spec_unit

// ===== tb/osa_ptr_mem.sv
// Memory side model that answers pointer reads of the specifier unit
`timescale 1ns/1ns
module osa_ptr_mem
  import osa_pkg::*;
#(
  parameter logic [31:0] PTR_PAT = 32'h5A5A_0000
)
(
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic        ptr_req_in,
  input  wire logic [31:0] ptr_addr_in,
  input  wire logic [3:0]  lat_in,
  output logic             ptr_ack_out,
  output logic [31:0]      ptr_data_out
);
  // ==========================================================================
  // Pointer read responder
  int unsigned wait_cnt;

  // Data toggles outside the ack cycle so a stale capture never matches
  initial
  begin
    ptr_ack_out  = 1'b0;
    ptr_data_out = 32'h0000_0000;
    wait_cnt     = 0;
    forever
    begin
      @(negedge mclk_in);
      if (ptr_ack_out)
      begin
        ptr_ack_out  = 1'b0;
        ptr_data_out = ~ptr_data_out;
      end
      else if (rstn_in && ptr_req_in && wait_cnt >= lat_in)
      begin
        ptr_ack_out  = 1'b1;
        ptr_data_out = ptr_addr_in ^ PTR_PAT;
        wait_cnt     = 0;
      end
      else
      begin
        if (ptr_req_in)
          wait_cnt++;
        ptr_data_out = ~ptr_data_out;
      end
    end
  end
endmodule : osa_ptr_mem

// ===== tb/test_operand_specifier_address_unit.sv
// Self-checking testbench of the operand specifier unit
`timescale 1ns/1ns
module test_operand_specifier_address_unit
  import osa_pkg::*;
;
  // ==========================================================================
  // Signals
  localparam logic [31:0] PAT = 32'h5A5A_0000;
  logic         mclk, rstn, spec_valid, ready, ptr_req, ptr_ack;
  logic         gpr_load, opnd_valid;
  logic [7:0]   spec_byte;
  logic [3:0]   gpr_num, lat, opnd_bytes;
  logic [31:0]  gpr_data, ptr_addr, ptr_data, opnd_addr;
  logic [63:0]  opnd_lit;
  osa_size_type spec_size, gpr_size;
  osa_kind_type opnd_kind;
  int           error_cnt = 0;
  int           samples_checked = 0;

  osa_spec_unit DUT (.mclk_in(mclk), .rstn_in(rstn), .spec_valid_in(spec_valid),
    .spec_byte_in(spec_byte), .spec_size_in(spec_size), .spec_ready_out(ready),
    .ptr_ack_in(ptr_ack), .ptr_data_in(ptr_data), .ptr_req_out(ptr_req),
    .ptr_addr_out(ptr_addr), .gpr_load_in(gpr_load), .gpr_load_num_in(gpr_num),
    .gpr_load_data_in(gpr_data), .gpr_load_size_in(gpr_size),
    .opnd_valid_out(opnd_valid), .opnd_kind_out(opnd_kind), .opnd_addr_out(opnd_addr),
    .opnd_bytes_out(opnd_bytes), .opnd_lit_out(opnd_lit));

  osa_ptr_mem #(.PTR_PAT(PAT)) MEM (.mclk_in(mclk), .rstn_in(rstn), .ptr_req_in(ptr_req),
    .ptr_addr_in(ptr_addr), .lat_in(lat), .ptr_ack_out(ptr_ack), .ptr_data_out(ptr_data));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================================================
  // Helpers
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [3:0] nbytes(input int s);
    case (s)
      0:       nbytes = 4'h1;
      1:       nbytes = 4'h2;
      2, 4:    nbytes = 4'h4;
      default: nbytes = 4'h8;
    endcase
  endfunction : nbytes

  task automatic load(input logic [3:0] num, input logic [31:0] d, input osa_size_type sz);
    @(negedge mclk);
    gpr_load = 1'b1;
    gpr_num  = num;
    gpr_data = d;
    gpr_size = sz;
    @(negedge mclk);
    gpr_load = 1'b0;
  endtask : load

  // Offer one specifier and wait, bounded, for its answer
  task automatic issue(input logic [7:0] b, input int s);
    int n;
    @(negedge mclk);
    spec_valid = 1'b1;
    spec_byte  = b;
    spec_size  = osa_size_type'(3'(s));
    @(negedge mclk);
    spec_valid = 1'b0;
    for (n = 0; n < 60 && opnd_valid !== 1'b1; n++)
      @(negedge mclk);
    if (n == 60)
    begin
      error_cnt++;
      $display("CHECK FAILED answer timeout expected pulse seen none");
      end_sim();
    end
    chk("ready", 64'(ready), 64'h0);
    @(negedge mclk);
    chk("valid_pulse", 64'(opnd_valid), 64'h0);
  endtask : issue

  task automatic chk_addr(input logic [31:0] a, input int s);
    chk("kind", 64'(opnd_kind), 64'(OSA_K_ADDRESS));
    chk("addr", 64'(opnd_addr), 64'(a));
    chk("bytes", 64'(opnd_bytes), 64'(nbytes(s)));
  endtask : chk_addr

  // ==========================================================================
  // Scenarios; no specifier names the program counter in modes 6 or 7
  task automatic t_reset;
    chk("valid", 64'(opnd_valid), 64'h0);
    chk("ptr_req", 64'(ptr_req), 64'h0);
    chk("kind", 64'(opnd_kind), 64'(OSA_K_NONE));
    chk("ready", 64'(ready), 64'h0);
  endtask : t_reset

  task automatic t_deferred;
    load(4'h4, 32'h0000_1010, OSA_SZ_LONG);
    chk("ready", 64'(ready), 64'h1);
    repeat (2)
    begin
      issue(8'h64, 3);
      chk_addr(32'h0000_1010, 3);
    end
  endtask : t_deferred

  task automatic t_autoinc;
    logic [31:0] a;
    a = 32'h0000_2000;
    load(4'h1, a, OSA_SZ_LONG);
    for (int s = 0; s < 6; s++)
    begin
      issue(8'h81, s);
      chk_addr(a, s);
      a = a + 32'(nbytes(s));
    end
  endtask : t_autoinc

  task automatic t_autodec;
    logic [31:0] a;
    a = 32'h0000_3000;
    load(4'h3, a, OSA_SZ_LONG);
    for (int s = 0; s < 6; s++)
    begin
      a = a - 32'(nbytes(s));
      issue(8'h73, s);
      chk_addr(a, s);
    end
  endtask : t_autodec

  task automatic t_inc_deferred;
    logic [31:0] a;
    a = 32'h0000_4000;
    load(4'h2, a, OSA_SZ_LONG);
    for (int k = 0; k < 4; k++)
    begin
      lat = (k < 2) ? 4'h0 : 4'h5;
      issue(8'h92, (k % 2 == 0) ? 1 : 5);
      chk_addr(a ^ PAT, (k % 2 == 0) ? 1 : 5);
      chk("ptr_addr", 64'(ptr_addr), 64'(a));
      chk("ptr_req", 64'(ptr_req), 64'h0);
      a = a + 32'h0000_0004;
    end
  endtask : t_inc_deferred

  task automatic t_pc_forms;
    issue(8'h8F, 2);
    chk("kind", 64'(opnd_kind), 64'(OSA_K_IMMEDIATE));
    issue(8'h9F, 2);
    chk("kind", 64'(opnd_kind), 64'(OSA_K_ABSOLUTE));
    chk("ptr_req", 64'(ptr_req), 64'h0);
    issue(8'h51, 2);
    chk("kind", 64'(opnd_kind), 64'(OSA_K_RESERVED));
  endtask : t_pc_forms

  task automatic t_word_load;
    load(4'h5, 32'hFFFF_FFFF, OSA_SZ_LONG);
    load(4'h5, 32'h0000_1234, OSA_SZ_WORD);
    issue(8'h65, 2);
    chk("addr_low", 64'(opnd_addr[15:0]), 64'h1234);
  endtask : t_word_load

  task automatic t_literals;
    logic [5:0]  v;
    logic [63:0] f;
    for (int k = 0; k < 5; k++)
    begin
      v = (k == 4) ? 6'h3F : 6'(k * 14);
      issue({2'b00, v}, 2);
      chk("kind", 64'(opnd_kind), 64'(OSA_K_LITERAL));
      chk("int_lit", opnd_lit, 64'(v));
      chk("bytes", 64'(opnd_bytes), 64'h4);
      f = 64'h0000_0000_0000_4000;
      f[9:7] = v[5:3];
      f[6:4] = v[2:0];
      for (int s = 4; s < 6; s++)
      begin
        issue({2'b00, v}, s);
        chk("flt_lit", opnd_lit, f);
        chk("bytes", 64'(opnd_bytes), 64'(nbytes(s)));
      end
    end
  endtask : t_literals

  // ==========================================================================
  // Main sequence
  initial
  begin
    rstn       = 1'b0;
    spec_valid = 1'b0;
    spec_byte  = 8'h00;
    spec_size  = OSA_SZ_BYTE;
    gpr_load   = 1'b0;
    gpr_num    = 4'h0;
    gpr_data   = 32'h0000_0000;
    gpr_size   = OSA_SZ_LONG;
    lat        = 4'h0;
    repeat (6) @(negedge mclk);
    t_reset();
    rstn = 1'b1;
    t_deferred();
    t_autoinc();
    t_autodec();
    t_inc_deferred();
    t_pc_forms();
    t_word_load();
    t_literals();
    end_sim();
  end
endmodule : test_operand_specifier_address_unit
